// [core/block_framer.sv]
// 64b/66b block framer with marker stream and parity insertion
`timescale 1ns/1ps

// What this block does
// - Eight incoming frame octets are packed into one 64-bit block payload.
// - Payload is scrambled first, then the 2-bit marker is added.
// - Marker occupies positions 0-1, octet k occupies positions 8k+2 to 8k+9.
// - Every multiblock holds 32 blocks unless a reference edge cuts it short.
// - Only one multiblock per extended group; frames must fit whole multiblocks.
// - Reference pulse resets the extended-group timing clock to a fixed phase.
// - Marker is always complementary: 01 sends one, 10 sends zero.
// - Marker bits of the 32 blocks form a stream word, bit 0 first.
// - Only the CRC-12 and FEC stream formats exist.
// - Stream ends in 00001 and in CRC mode never shows it elsewhere.
// - Stream bit 22 is one on the last multiblock of each group.
// - In CRC mode, parity over the 2048 scrambled payload bits goes in the next multiblock.
// - Parity polynomial is x^12+x^9+x^8+x^3+x^2+x+1.
// - Parity register starts at zero each multiblock, read after 2048 bits.
// - CRC mode places parity bits in triplets and forces the fixed pilot bits.
// - CRC mode sends the seven command bits as zeros.
// - Earliest detection of a first-bit error is 46 blocks later.
module block_framer
  import link66_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Configuration
  input wire logic link_en_i,
  input wire logic fec_mode_i,
  input wire logic scr_bypass_i,
  input wire logic [FEC_W-1:0] fec_parity_i,
  // Frame octets from the transport side
  input wire logic [7:0] octet_i,
  input wire logic octet_valid_i,
  // Reference pulse pin
  input wire logic system_reference_pulse_i,
  // Coded block output
  output coded_block_t block_o,
  output logic block_valid_o,
  output logic [BLK_IDX_W-1:0] block_index_o,
  // Multiblock timing
  output logic multiblock_end_pilot_o,
  output logic extended_group_end_flag_o,
  output logic extended_group_timing_clock_o,
  // Status
  output logic [CRC_W-1:0] last_parity_o,
  output logic realign_o
);

  // Reference synchroniser and edge detect
  logic ref_meta_q;
  logic ref_sync_q;
  logic ref_prev_q;
  logic ref_rise;
  logic realign_pend_q;

  // Packing state
  logic [55:0] pack_q;
  logic [OCTET_CNT_W-1:0] oct_cnt_q;
  logic blk_go;
  logic [PAYLOAD_BITS-1:0] word_c;
  logic [PAYLOAD_BITS-1:0] scr_word;

  // Multiblock state
  logic [BLK_IDX_W-1:0] blk_cnt_q;
  logic [BLK_IDX_W-1:0] cur_idx;
  logic [CRC_W-1:0] crc_acc_q;
  logic [CRC_W-1:0] crc_prev_q;
  logic [CRC_W-1:0] crc_base;
  logic [CRC_W-1:0] crc_new;
  parity_mode_t mode_q;
  parity_mode_t mode_sel;
  logic [STREAM_BITS-1:0] tx_stream_q;
  logic [STREAM_BITS-1:0] stream_crc;
  logic [STREAM_BITS-1:0] stream_fec;
  logic [STREAM_BITS-1:0] stream_sel;
  logic marker_bit;

  // Pin is asynchronous; only the second stage is looked at
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_meta_q <= 1'h0;
      ref_sync_q <= 1'h0;
      ref_prev_q <= 1'h0;
    end
    else if (clk_en_i)
    begin
      ref_meta_q <= system_reference_pulse_i;
      ref_sync_q <= ref_meta_q;
      ref_prev_q <= ref_sync_q;
    end
  end

  // A periodic reference that divides the multiblock rate lands on block 0 again
  assign ref_rise = ref_sync_q & ~ref_prev_q;

  // Pending realignment; a new edge wins over the clear by the next block
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      realign_pend_q <= 1'h0;
    end
    else if (clk_en_i)
    begin
      if (ref_rise)
      begin
        realign_pend_q <= 1'h1;
      end
      else if (blk_go)
      begin
        realign_pend_q <= 1'h0;
      end
    end
  end

  // A block leaves in the cycle its eighth octet arrives
  assign blk_go = link_en_i & octet_valid_i & (oct_cnt_q == OCTET_LAST);
  assign word_c = {octet_i, pack_q};

  // Octet k lands in payload bits 8k+7..8k
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pack_q <= '0;
      oct_cnt_q <= '0;
    end
    else if (clk_en_i)
    begin
      if (!link_en_i)
      begin
        oct_cnt_q <= '0;
      end
      else if (octet_valid_i)
      begin
        if (oct_cnt_q != OCTET_LAST)
        begin
          pack_q[{oct_cnt_q, 3'h0} +: 8] <= octet_i;
        end
        oct_cnt_q <= oct_cnt_q + 3'h1;
      end
    end
  end

  // Scrambling happens on the packed word before any marker is attached
  block_scrambler u_scr (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .advance_i(blk_go),
    .bypass_i(scr_bypass_i),
    .data_i(word_c),
    .data_o(scr_word)
  );

  // Reference forces the next block to be block 0 of a multiblock
  assign cur_idx = realign_pend_q ? BLK_FIRST : blk_cnt_q;

  // Parity starts from zero at block 0, so a realign also restarts it
  assign crc_base = (cur_idx == BLK_FIRST) ? CRC_RESET : crc_acc_q;

  // Polynomial taps live in the step module
  crc12_step u_crc (
    .crc_i(crc_base),
    .data_i(scr_word),
    .crc_o(crc_new)
  );

  // Block counter wraps after 32 blocks
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      blk_cnt_q <= BLK_FIRST;
    end
    else if (clk_en_i && blk_go)
    begin
      blk_cnt_q <= cur_idx + 5'h01;
    end
  end

  // Parity accumulates over 2048 scrambled bits, handed over at the last block
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      crc_acc_q <= CRC_RESET;
      crc_prev_q <= CRC_RESET;
    end
    else if (clk_en_i && blk_go)
    begin
      if (cur_idx == BLK_LAST)
      begin
        crc_prev_q <= crc_new;
        crc_acc_q <= CRC_RESET;
      end
      else
      begin
        crc_acc_q <= crc_new;
      end
    end
  end

  // CRC format: parity triplets, command bits zero, fixed ones, pilot tail
  assign stream_crc = {1'h1, 4'h0, 3'h0, 1'h1, EXT_GROUP_END_FLAG, 1'h1, 1'h0, 1'h1, 3'h0,
                       1'h1, crc_prev_q[0], crc_prev_q[1], crc_prev_q[2],
                       1'h1, crc_prev_q[3], crc_prev_q[4], crc_prev_q[5],
                       1'h1, crc_prev_q[6], crc_prev_q[7], crc_prev_q[8],
                       1'h1, crc_prev_q[9], crc_prev_q[10], crc_prev_q[11]};

  // FEC format: parity word supplied by the FEC generator outside
  always_comb
  begin
    stream_fec = '0;
    for (int i = 0; i < 22; i++)
    begin
      stream_fec[i] = fec_parity_i[FEC_W-1-i];
    end
    for (int j = 0; j < 4; j++)
    begin
      stream_fec[26-j] = fec_parity_i[j];
    end
    stream_fec[EXT_END_POS] = EXT_GROUP_END_FLAG;
    stream_fec[STREAM_BITS-1 -: 5] = PILOT_TAIL;
  end

  // Mode is only taken at a multiblock start, so one stream never mixes formats
  assign mode_sel = (cur_idx == BLK_FIRST) ? (fec_mode_i ? PAR_FEC : PAR_CRC12) : mode_q;

  // A fresh stream word is built at block 0 and then held for the multiblock
  always_comb
  begin
    stream_sel = tx_stream_q;
    if (cur_idx == BLK_FIRST)
    begin
      unique case (mode_sel)
        PAR_CRC12: stream_sel = stream_crc;
        PAR_FEC: stream_sel = stream_fec;
      endcase
    end
  end

  // Block n carries stream bit n
  assign marker_bit = stream_sel[cur_idx];

  // Stream word and mode registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_stream_q <= '0;
      mode_q <= PAR_CRC12;
    end
    else if (clk_en_i && blk_go)
    begin
      tx_stream_q <= stream_sel;
      mode_q <= mode_sel;
    end
  end

  // Coded block register; the marker never shows 00 or 11
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      block_o <= '0;
      block_index_o <= BLK_FIRST;
    end
    else if (clk_en_i && blk_go)
    begin
      block_o.payload <= scr_word;
      block_o.block_marker_bits <= marker_bit ? MARKER_ONE : MARKER_ZERO;
      block_index_o <= cur_idx;
    end
  end

  // Strobes and timing clock; half high, half low per multiblock
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      block_valid_o <= 1'h0;
      multiblock_end_pilot_o <= 1'h0;
      extended_group_end_flag_o <= 1'h0;
      extended_group_timing_clock_o <= 1'h0;
      realign_o <= 1'h0;
    end
    else if (clk_en_i)
    begin
      block_valid_o <= blk_go;
      multiblock_end_pilot_o <= blk_go & (cur_idx == BLK_LAST);
      // With one multiblock per group every multiblock end is a group end
      extended_group_end_flag_o <= blk_go & (cur_idx == BLK_LAST);
      realign_o <= blk_go & realign_pend_q;
      if (blk_go)
      begin
        extended_group_timing_clock_o <= (cur_idx < BLK_HALF);
      end
    end
  end

  // Parity of the previous multiblock; the receiver sees it 46 blocks late at best
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      last_parity_o <= CRC_RESET;
    end
    else if (clk_en_i && blk_go && (cur_idx == BLK_LAST))
    begin
      last_parity_o <= crc_new;
    end
  end

  // Marker is always complementary
  a_marker_complement: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    block_valid_o |-> (block_o.block_marker_bits[0] != block_o.block_marker_bits[1]))
    else $error("marker bits not complementary");

  // Marker carries the stream bit of its block position
  a_marker_stream_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    block_valid_o |-> (block_o.block_marker_bits[1] == tx_stream_q[block_index_o]))
    else $error("marker does not match stream word bit");

  // Stream ends with the pilot tail
  a_pilot_tail: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    block_valid_o |-> (tx_stream_q[STREAM_BITS-1:PILOT_LSB] == PILOT_TAIL))
    else $error("stream word lacks end pilot");

  // Group end bit set in every multiblock
  a_group_end_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    block_valid_o |-> tx_stream_q[EXT_END_POS])
    else $error("group end bit clear");

  // Fixed ones in CRC format
  a_crc_fixed_ones: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (block_valid_o && mode_q == PAR_CRC12) |->
      (tx_stream_q[3] && tx_stream_q[7] && tx_stream_q[11] && tx_stream_q[15] &&
       tx_stream_q[19] && tx_stream_q[21] && tx_stream_q[23]))
    else $error("fixed one missing in CRC stream");

  // Command bits zero in CRC format
  a_cmd_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (block_valid_o && mode_q == PAR_CRC12) |->
      (tx_stream_q[18:16] == 3'h0 && !tx_stream_q[20] && tx_stream_q[26:24] == 3'h0))
    else $error("command bit set in CRC stream");

  // Parity of a multiblock shows up in the next one
  a_parity_carry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (block_valid_o && block_index_o == BLK_FIRST && mode_q == PAR_CRC12) |->
      ({tx_stream_q[0], tx_stream_q[1], tx_stream_q[2], tx_stream_q[4]} ==
       last_parity_o[CRC_W-1 -: 4]))
    else $error("stream parity differs from previous multiblock");

  // Pilot strobe only on block 31
  a_mb_end_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    block_valid_o |-> (multiblock_end_pilot_o == (block_index_o == BLK_LAST)))
    else $error("multiblock end strobe misplaced");

  // Parity restarts from zero after the last block
  a_parity_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && blk_go && cur_idx == BLK_LAST) |=> (crc_acc_q == CRC_RESET))
    else $error("parity not cleared at multiblock end");

  // Reference edge forces block 0 on the next block
  a_ref_realign: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && blk_go && realign_pend_q && !ref_rise) |=>
      (block_index_o == BLK_FIRST && extended_group_timing_clock_o && !realign_pend_q))
    else $error("reference did not realign multiblock");

  // Index steps by one between blocks
  a_index_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && blk_go && !realign_pend_q) |=> (block_index_o == $past(blk_cnt_q)))
    else $error("block index skipped");

endmodule : block_framer

// [core/link66_pkg.sv]
// Shared constants and carrier types for the 64b/66b block framer
package link66_pkg;

  // Block geometry
  localparam int OCTETS_PER_BLOCK = 8;
  localparam int PAYLOAD_BITS = 64;
  localparam int MARKER_BITS = 2;
  localparam int CODED_BITS = 66;
  localparam int OCTET_CNT_W = 3;
  localparam logic [OCTET_CNT_W-1:0] OCTET_LAST = 3'h7;

  // Multiblock geometry
  localparam int BLOCKS_PER_MB = 32;
  localparam int BLK_IDX_W = 5;
  localparam logic [BLK_IDX_W-1:0] BLK_FIRST = 5'h00;
  localparam logic [BLK_IDX_W-1:0] BLK_LAST = 5'h1F;
  localparam logic [BLK_IDX_W-1:0] BLK_HALF = 5'h10;
  localparam int MB_PAYLOAD_BITS = 2048;

  // Multiblocks per extended group; only one is supported
  localparam int MB_PER_EXT_GROUP = 1;
  localparam logic EXT_GROUP_END_FLAG = 1'h1;

  // Marker patterns, bit 0 is sent first
  localparam logic [1:0] MARKER_ONE = 2'h2;
  localparam logic [1:0] MARKER_ZERO = 2'h1;

  // Marker stream layout
  localparam int STREAM_BITS = 32;
  localparam int EXT_END_POS = 22;
  localparam logic [4:0] PILOT_TAIL = 5'h10;
  localparam int PILOT_LSB = 27;

  // Parity generator, polynomial in implicit-plus-one notation
  localparam int CRC_W = 12;
  localparam logic [CRC_W-1:0] CRC_POLY_IMPLICIT = 12'h987;
  localparam logic [CRC_W-1:0] CRC_TAPS = {CRC_POLY_IMPLICIT[10:0], 1'h1};
  localparam logic [CRC_W-1:0] CRC_RESET = 12'h000;
  localparam int FEC_W = 26;
  localparam int DETECT_LATENCY_BLOCKS = 46;

  // Scrambler taps
  localparam int SCR_TAP_A = 39;
  localparam int SCR_TAP_B = 58;

  // Parity format of the marker stream
  typedef enum logic {PAR_CRC12, PAR_FEC} parity_mode_t;

  // One coded block: bit i is the i-th transmitted bit
  typedef struct packed {
    logic [PAYLOAD_BITS-1:0] payload;
    logic [MARKER_BITS-1:0] block_marker_bits;
  } coded_block_t;

endpackage : link66_pkg

// [core/crc12_step.sv]
// Serial-order parity update over one payload word
`timescale 1ns/1ps
module crc12_step
  import link66_pkg::*;
#(
  parameter int DATA_W = PAYLOAD_BITS
)
(
  // Running parity and data
  input wire logic [CRC_W-1:0] crc_i,
  input wire logic [DATA_W-1:0] data_i,
  // Updated parity
  output logic [CRC_W-1:0] crc_o
);

  // Bit 0 of the word enters first, matching transmission order
  always_comb
  begin
    logic [CRC_W-1:0] c;
    logic fb;
    c = crc_i;
    fb = 1'h0;
    for (int i = 0; i < DATA_W; i++)
    begin
      fb = c[CRC_W-1] ^ data_i[i];
      c = {c[CRC_W-2:0], 1'h0};
      if (fb)
      begin
        c = c ^ CRC_TAPS;
      end
    end
    crc_o = c;
  end

endmodule : crc12_step

// [core/block_scrambler.sv]
// Self-synchronous payload scrambler, one word per advance
`timescale 1ns/1ps
module block_scrambler
  import link66_pkg::*;
#(
  parameter int DATA_W = PAYLOAD_BITS,
  parameter int TAP_A = SCR_TAP_A,
  parameter int TAP_B = SCR_TAP_B
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Control
  input wire logic advance_i,
  input wire logic bypass_i,
  // Data
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o
);

  logic [TAP_B-1:0] state_q;
  logic [TAP_B-1:0] state_d;

  // Serial model unrolled over the word; state holds past output bits
  always_comb
  begin
    logic [TAP_B-1:0] s;
    logic b;
    s = state_q;
    b = 1'h0;
    data_o = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      b = bypass_i ? data_i[i] : (data_i[i] ^ s[TAP_A-1] ^ s[TAP_B-1]);
      data_o[i] = b;
      s = {s[TAP_B-2:0], b};
    end
    state_d = s;
  end

  // State moves only when a word is really consumed
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= '0;
    end
    else if (clk_en_i && advance_i)
    begin
      state_q <= state_d;
    end
  end

endmodule : block_scrambler

// [bench/link_receiver.sv]
// Far-end receiver model: marker stream recovery and multiblock parity
`timescale 1ns/1ps
module link_receiver
  import link66_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Coded blocks from the framer
  input wire coded_block_t block_i,
  input wire logic valid_i,
  input wire logic realign_i,
  // Recovered multiblock view
  output logic [STREAM_BITS-1:0] stream_o,
  output logic [CRC_W-1:0] crc_o,
  output logic [BLK_IDX_W-1:0] idx_o,
  output int mb_cnt_o,
  output int hdr_err_o
);
  logic [CRC_W-1:0] crc_q;
  logic [STREAM_BITS-1:0] word_q;
  logic [CRC_W-1:0] c;
  logic [STREAM_BITS-1:0] w;
  logic [BLK_IDX_W-1:0] i;
  logic fb;

  // Folds the block on the wires into the running multiblock view
  always_comb
  begin
    // The shared reference restarts framing on this side too
    i = (realign_i === 1'h1) ? BLK_FIRST : idx_o;
    c = (i == BLK_FIRST) ? CRC_RESET : crc_q;
    w = (i == BLK_FIRST) ? 32'h0000_0000 : word_q;
    fb = 1'h0;
    w[i] = (block_i.block_marker_bits === 2'h2);
    for (int b = 0; b < 64; b++)
    begin
      fb = c[11] ^ block_i.payload[b];
      c = {c[10:0], 1'h0} ^ (fb ? 12'h30F : 12'h000);
    end
  end

  // State moves only on a block strobe
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      crc_q <= CRC_RESET;
      word_q <= 32'h0000_0000;
      stream_o <= 32'h0000_0000;
      crc_o <= CRC_RESET;
      idx_o <= BLK_FIRST;
      mb_cnt_o <= 0;
      hdr_err_o <= 0;
    end
    else if (valid_i === 1'h1)
    begin
      // Equal marker bits would mean lost block alignment
      if (block_i.block_marker_bits[0] === block_i.block_marker_bits[1])
      begin
        hdr_err_o <= hdr_err_o + 1;
      end
      crc_q <= c;
      word_q <= w;
      idx_o <= i + 5'h01;
      if (i == BLK_LAST)
      begin
        stream_o <= w;
        crc_o <= c;
        mb_cnt_o <= mb_cnt_o + 1;
      end
    end
  end
endmodule : link_receiver

// [bench/block_framer_test.sv]
// Self-checking testbench for the 64b/66b block framer
`timescale 1ns/1ps
module block_framer_test
  import link66_pkg::*;
;
  logic clk_i;
  logic rst_b_i;
  logic clk_en_i;
  logic link_en_i;
  logic fec_mode_i;
  logic scr_bypass_i;
  logic [FEC_W-1:0] fec_parity_i;
  logic [7:0] octet_i;
  logic octet_valid_i;
  logic system_reference_pulse_i;
  coded_block_t block_o;
  logic block_valid_o;
  logic [BLK_IDX_W-1:0] block_index_o;
  logic multiblock_end_pilot_o;
  logic extended_group_end_flag_o;
  logic extended_group_timing_clock_o;
  logic [CRC_W-1:0] last_parity_o;
  logic realign_o;
  logic [STREAM_BITS-1:0] rx_stream;
  logic [CRC_W-1:0] rx_crc;
  logic [BLK_IDX_W-1:0] rx_idx;
  int mb_cnt;
  int hdr_err;
  int checks;
  int miscompares;
  logic exp_realign;
  logic [31:0] blk_no;
  logic [CRC_W-1:0] prev;

  block_framer u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .link_en_i(link_en_i), .fec_mode_i(fec_mode_i), .scr_bypass_i(scr_bypass_i),
    .fec_parity_i(fec_parity_i), .octet_i(octet_i), .octet_valid_i(octet_valid_i),
    .system_reference_pulse_i(system_reference_pulse_i), .block_o(block_o),
    .block_valid_o(block_valid_o), .block_index_o(block_index_o),
    .multiblock_end_pilot_o(multiblock_end_pilot_o),
    .extended_group_end_flag_o(extended_group_end_flag_o),
    .extended_group_timing_clock_o(extended_group_timing_clock_o),
    .last_parity_o(last_parity_o), .realign_o(realign_o));

  link_receiver u_rx (.clk_i(clk_i), .rst_b_i(rst_b_i), .block_i(block_o),
    .valid_i(block_valid_o), .realign_i(realign_o), .stream_o(rx_stream),
    .crc_o(rx_crc), .idx_o(rx_idx), .mb_cnt_o(mb_cnt), .hdr_err_o(hdr_err));

  // 200 MHz clock
  initial
  begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [65:0] seen, input logic [65:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Expected CRC-mode stream: parity triplets, fixed ones, group end flag set
  function automatic logic [31:0] crc_stream(input logic [11:0] c);
    logic [31:0] s;
    s = 32'h80E8_8888;
    for (int t = 0; t < 4; t++)
      for (int j = 0; j < 3; j++)
        s[4*t+j] = c[11-3*t-j];
    return s;
  endfunction : crc_stream

  function automatic logic [31:0] fec_stream(input logic [25:0] f);
    logic [31:0] s;
    s = 32'h8040_0000;
    for (int j = 0; j < 22; j++)
      s[j] = f[25-j];
    for (int j = 0; j < 4; j++)
      s[23+j] = f[3-j];
    return s;
  endfunction : fec_stream

  // Sends eight octets, waits for the block and checks its timing outputs
  task automatic send_block(input logic [63:0] d);
    int n;
    logic [4:0] ei;
    for (int k = 0; k < 8; k++)
    begin
      octet_i = d[8*k +: 8];
      octet_valid_i = 1'h1;
      @(posedge clk_i);
      #1;
    end
    octet_valid_i = 1'h0;
    n = 0;
    while (block_valid_o !== 1'h1 && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    ei = exp_realign ? 5'h00 : rx_idx;
    check(block_valid_o, 1'h1, "block valid");
    check(block_index_o, ei, "block index");
    check(realign_o, exp_realign, "realign");
    check(extended_group_timing_clock_o, ei < 5'h10, "timing clock");
    check(multiblock_end_pilot_o, ei == 5'h1F, "pilot pulse");
    check(extended_group_end_flag_o, ei == 5'h1F, "group end");
    exp_realign = 1'h0;
    // One idle edge so a following call never re-raises valid in this time step
    @(posedge clk_i);
    #1;
  endtask : send_block

  task automatic run_mb();
    int c0;
    c0 = mb_cnt;
    repeat (40)
    begin
      send_block({blk_no, ~blk_no});
      blk_no++;
      @(posedge clk_i);
      #1;
      if (mb_cnt != c0)
        break;
    end
    check(mb_cnt != c0, 1'h1, "multiblock seen");
  endtask : run_mb

  // Unscrambled block shows octet placement and a zero marker
  task automatic t_pack();
    scr_bypass_i = 1'h1;
    send_block(64'h0123_4567_89AB_CDEF);
    check(block_o.payload, 64'h0123_4567_89AB_CDEF, "payload");
    check(block_o[9:2], 8'hEF, "octet 0 place");
    check(block_o[65:58], 8'h01, "octet 7 place");
    check(block_o.block_marker_bits, 2'h1, "zero marker");
    // Octets offered while the enable is low must not be taken
    octet_i = 8'hAA;
    octet_valid_i = 1'h1;
    clk_en_i = 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
    clk_en_i = 1'h1;
    octet_valid_i = 1'h0;
    @(posedge clk_i);
    #1;
    send_block(64'h7766_5544_3322_1100);
    check(block_o.payload, 64'h7766_5544_3322_1100, "frozen octets");
    // A link drop throws away the partial block
    octet_valid_i = 1'h1;
    repeat (3) @(posedge clk_i);
    #1;
    octet_valid_i = 1'h0;
    link_en_i = 1'h0;
    @(posedge clk_i);
    #1;
    link_en_i = 1'h1;
    send_block(64'h8899_AABB_CCDD_EEFF);
    check(block_o.payload, 64'h8899_AABB_CCDD_EEFF, "dropped octets");
    scr_bypass_i = 1'h0;
    $display("test pack done");
  endtask : t_pack

  // Reference edge mid-multiblock restarts the index
  task automatic t_realign();
    send_block(64'hFEDC_BA98_7654_3210);
    send_block(64'h0000_0000_FFFF_FFFF);
    system_reference_pulse_i = 1'h1;
    repeat (2) @(posedge clk_i);
    #1;
    system_reference_pulse_i = 1'h0;
    repeat (5) @(posedge clk_i);
    #1;
    exp_realign = 1'h1;
    send_block(64'h5A5A_5A5A_A5A5_A5A5);
    $display("test realign done");
  endtask : t_realign

  // Each multiblock carries the parity of the one before
  task automatic t_crc();
    for (int m = 0; m < 3; m++)
    begin
      prev = rx_crc;
      run_mb();
      check(rx_stream, crc_stream(prev), "crc stream");
      send_block(64'h1111_2222_3333_4444);
      check(last_parity_o, rx_crc, "last parity");
    end
    $display("test crc done");
  endtask : t_crc

  task automatic t_fec();
    fec_parity_i = 26'h2A5_C3F1;
    fec_mode_i = 1'h1;
    run_mb();
    run_mb();
    check(rx_stream, fec_stream(26'h2A5_C3F1), "fec stream");
    fec_mode_i = 1'h0;
    run_mb();
    prev = rx_crc;
    run_mb();
    check(rx_stream, crc_stream(prev), "crc after fec");
    check(hdr_err, 66'h0, "marker pairs");
    $display("test fec done");
  endtask : t_fec

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    checks = 0;
    miscompares = 0;
    exp_realign = 1'h0;
    blk_no = 32'h0000_0000;
    rst_b_i = 1'h0;
    clk_en_i = 1'h1;
    link_en_i = 1'h1;
    fec_mode_i = 1'h0;
    scr_bypass_i = 1'h0;
    fec_parity_i = 26'h000_0000;
    octet_i = 8'h00;
    octet_valid_i = 1'h0;
    system_reference_pulse_i = 1'h0;
    repeat (12) @(posedge clk_i);
    #1;
    rst_b_i = 1'h1;
    t_pack();
    t_realign();
    t_crc();
    t_fec();
    final_report();
  end

  // Roughly 250 blocks of some 10 cycles each; allow four times that
  initial
  begin
    #50us;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : block_framer_test
